// [hdl/bsr_pkg.sv]
package bsr_pkg;

    // -------------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------------
    localparam int BSR_WORD_W = 18;
    localparam int BSR_BYTE_W = 9;
    localparam int BSR_ADDR_W = 20;
    localparam int BSR_BURST  = 4;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int BSR_CLK_MHZ      = 125;
    localparam int BSR_PLL_LOCK_US  = 100;
    localparam int BSR_PLL_LOCK_CYC = BSR_PLL_LOCK_US * BSR_CLK_MHZ;
    localparam int BSR_PLL_STOP_NS  = 30;
    localparam int BSR_PLL_STOP_CYC = (BSR_PLL_STOP_NS * BSR_CLK_MHZ + 999) / 1000;
    localparam int BSR_ZQ_PERIOD    = 1024;
    localparam int BSR_K_HALF_CYC   = 10;

    // edge phases counted from the start edge (phase 0 = k rise)
    localparam int BSR_RD_FIRST_PLL = 5;
    localparam int BSR_RD_FIRST_LEG = 2;
    localparam int BSR_RD_DEPTH     = 9;
    localparam int BSR_WR_DEPTH     = 5;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        BSR_START_NONE  = 2'b00,
        BSR_START_READ  = 2'b01,
        BSR_START_WRITE = 2'b10
    } bsr_start_t;

    typedef enum logic [1:0] {
        BSR_CTL_IDLE  = 2'b00,
        BSR_CTL_WRITE = 2'b01,
        BSR_CTL_READ  = 2'b10
    } bsr_ctl_state_t;

endpackage : bsr_pkg

// [hdl/bsr_link_if.sv]
interface bsr_link_if #(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 20
) ();
    localparam int NB = WORD_W / 9;

    logic              k;
    logic              k_n;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic              pll_disable_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
    logic [NB-1:0]     byte_write_select_n;
    logic [WORD_W-1:0] q;
    logic              q_oe_n;
    logic              echo_clock;
    logic              echo_clock_n;
    logic              read_data_valid;

    modport dev (
        input  k, k_n, read_port_select_n, write_port_select_n, pll_disable_n,
        input  addr, d, byte_write_select_n,
        output q, q_oe_n, echo_clock, echo_clock_n, read_data_valid
    );

    modport ctl (
        output k, k_n, read_port_select_n, write_port_select_n, pll_disable_n,
        output addr, d, byte_write_select_n,
        input  q, q_oe_n, echo_clock, echo_clock_n, read_data_valid
    );

endinterface : bsr_link_if

// [hdl/bsr_sram_ctl.sv]
module bsr_sram_ctl
    import bsr_pkg::*;
#(
    parameter int WORD_W = BSR_WORD_W,
    parameter int ADDR_W = BSR_ADDR_W,
    parameter int K_HALF = BSR_K_HALF_CYC
) (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    bsr_link_if.ctl                             link,
    input  wire logic                           user_pll_disable_n,
    input  wire logic                           cmd_valid,
    input  wire logic                           cmd_write,
    input  wire logic [ADDR_W-1:0]              cmd_addr,
    input  wire logic [BSR_BURST*WORD_W-1:0]    cmd_wdata,
    input  wire logic [BSR_BURST*WORD_W/9-1:0]  cmd_wbyte_n,
    output logic                                cmd_ready,
    output logic                                rsp_valid,
    output logic [BSR_BURST*WORD_W-1:0]         rsp_rdata
);
    localparam int NB   = WORD_W / BSR_BYTE_W;
    localparam int CW   = $clog2(2 * K_HALF);
    localparam int L_RISE = K_HALF + K_HALF / 2;
    localparam int L_FALL = K_HALF / 2;

    // -------------------------------------------------------------------
    // link clock divider
    // -------------------------------------------------------------------
    logic [CW-1:0]     cnt_q;
    logic              k_d;
    logic              k_q;
    logic              k_n_q;
    logic              vld_seen_q;
    logic              launch_r;
    logic              launch;
    logic              sample;
    bsr_ctl_state_t    state_q;
    logic [2:0]        slot_q;
    logic [1:0]        widx_q;
    logic              take;

    assign launch_r = cnt_q == CW'(L_RISE);
    assign launch   = launch_r || cnt_q == CW'(L_FALL);
    // sample late in each half so the device's resynchronised answer has settled
    assign sample   = cnt_q == CW'(K_HALF - 1) || cnt_q == CW'(2 * K_HALF - 1);
    assign take     = launch_r && cmd_ready && cmd_valid;

    // free running: the link clock never stops, so no pll restart is ever forced
    assign k_d = (cnt_q == CW'(2 * K_HALF - 1)) || (cnt_q < CW'(K_HALF - 1));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
            k_q   <= 1'b0;
            k_n_q <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == CW'(2 * K_HALF - 1)) ? '0 : cnt_q + 1'b1;
            k_q   <= k_d;
            k_n_q <= !k_d;
        end
    end

    // -------------------------------------------------------------------
    // command sequencing, select, address and data pins change mid-phase; pll_disable_n follows the user input every clk
    // -------------------------------------------------------------------
    logic              rps_n_q;
    logic              wps_n_q;
    logic              pll_dis_n_q;
    logic [ADDR_W-1:0] addr_q;
    logic [WORD_W-1:0] d_q;
    logic [NB-1:0]     bws_n_q;
    logic [BSR_BURST*WORD_W-1:0] wdata_q;
    logic [BSR_BURST*NB-1:0]     wbyte_n_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q     <= BSR_CTL_IDLE;
            cmd_ready   <= 1'b0;
            rps_n_q     <= 1'b1;
            wps_n_q     <= 1'b1;
            pll_dis_n_q <= 1'b1;
            addr_q      <= '0;
            d_q         <= '0;
            bws_n_q     <= '1;
            slot_q      <= '0;
            wdata_q     <= '0;
            wbyte_n_q   <= '1;
        end else begin
            pll_dis_n_q <= user_pll_disable_n;
            cmd_ready   <= cnt_q == CW'(L_RISE - 1) && state_q == BSR_CTL_IDLE;
            if (launch) begin
                rps_n_q <= 1'b1;
                wps_n_q <= 1'b1;
            end
            if (take) begin
                // one burst at a time keeps starts at least two rises apart
                addr_q    <= cmd_addr;
                rps_n_q   <= cmd_write;
                wps_n_q   <= !cmd_write;
                wdata_q   <= cmd_wdata;
                wbyte_n_q <= cmd_wbyte_n;
                slot_q    <= '0;
                state_q   <= cmd_write ? BSR_CTL_WRITE : BSR_CTL_READ;
            end else if (launch && state_q == BSR_CTL_WRITE) begin
                slot_q <= slot_q + 1'b1;
                if (slot_q >= 3'd1 && slot_q <= 3'd4) begin
                    d_q     <= wdata_q[(slot_q - 3'd1) * WORD_W +: WORD_W];
                    bws_n_q <= wbyte_n_q[(slot_q - 3'd1) * NB +: NB];
                end
                if (slot_q == 3'd5) begin
                    state_q <= BSR_CTL_IDLE;
                    bws_n_q <= '1;
                end
            end else if (sample && state_q == BSR_CTL_READ && vld_seen_q && widx_q == 2'd3) begin
                state_q <= BSR_CTL_IDLE;
            end
        end
    end

    // -------------------------------------------------------------------
    // read capture, framed by the valid flag one half cycle ahead
    // -------------------------------------------------------------------
    logic [WORD_W:0]   rx_meta_q;
    logic [WORD_W:0]   rx_sync_q;

    always_ff @(posedge clk) begin
        rx_meta_q <= {link.read_data_valid, link.q};
        rx_sync_q <= rx_meta_q;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vld_seen_q <= 1'b0;
            widx_q     <= '0;
            rsp_valid  <= 1'b0;
            rsp_rdata  <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (sample) begin
                vld_seen_q <= rx_sync_q[WORD_W];
                if (vld_seen_q && state_q == BSR_CTL_READ) begin
                    rsp_rdata[widx_q * WORD_W +: WORD_W] <= rx_sync_q[WORD_W-1:0];
                    widx_q <= widx_q + 1'b1;
                    rsp_valid <= widx_q == 2'd3;
                end
            end
        end
    end

    assign link.k                   = k_q;
    assign link.k_n                 = k_n_q;
    assign link.read_port_select_n  = rps_n_q;
    assign link.write_port_select_n = wps_n_q;
    assign link.pll_disable_n       = pll_dis_n_q;
    assign link.addr                = addr_q;
    assign link.d                   = d_q;
    assign link.byte_write_select_n = bws_n_q;

endmodule : bsr_sram_ctl

// [hdl/bsr_sram_dev.sv]
module bsr_sram_dev
    import bsr_pkg::*;
#(
    parameter int WORD_W       = BSR_WORD_W,
    parameter int ADDR_W       = BSR_ADDR_W,
    parameter int PLL_LOCK_CYC = BSR_PLL_LOCK_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    bsr_link_if.dev   link,
    output logic      pll_locked,
    output logic      impedance_update
);
    localparam int NB   = WORD_W / BSR_BYTE_W;
    localparam int IN_W = 5 + ADDR_W + WORD_W + NB;
    localparam int LW   = $clog2(PLL_LOCK_CYC + 1);
    localparam int ZW   = $clog2(BSR_ZQ_PERIOD);

    // -------------------------------------------------------------------
    // pin synchronisers and link edge detection
    // -------------------------------------------------------------------
    logic [IN_W-1:0]   pin_meta_q;
    logic [IN_W-1:0]   pin_sync_q;
    logic              k_s;
    logic              kn_s;
    logic              rps_n_s;
    logic              wps_n_s;
    logic              pll_on_s;
    logic [ADDR_W-1:0] addr_s;
    logic [WORD_W-1:0] d_s;
    logic [NB-1:0]     bws_n_s;
    logic              k_prev_q;
    logic              kn_prev_q;
    logic              kr;
    logic              knr;
    logic              edge_k;

    // data and strobes share the clock's two-stage path so they stay aligned
    always_ff @(posedge clk) begin
        pin_meta_q <= {link.k, link.k_n, link.read_port_select_n, link.write_port_select_n,
                       link.pll_disable_n, link.addr, link.d, link.byte_write_select_n};
        pin_sync_q <= pin_meta_q;
    end

    assign {k_s, kn_s, rps_n_s, wps_n_s, pll_on_s, addr_s, d_s, bws_n_s} = pin_sync_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            k_prev_q  <= 1'b1;
            kn_prev_q <= 1'b1;
        end else begin
            k_prev_q  <= k_s;
            kn_prev_q <= kn_s;
        end
    end

    assign kr     = k_s && !k_prev_q;
    assign knr    = kn_s && !kn_prev_q;
    assign edge_k = kr || knr;

    // -------------------------------------------------------------------
    // start arbitration
    // -------------------------------------------------------------------
    bsr_start_t last_q;
    logic       start_rd;
    logic       start_wr;

    // selects only count on a k rise
    assign start_rd = kr && !rps_n_s && last_q != BSR_START_READ;
    assign start_wr = kr && !wps_n_s && !start_rd
                      && last_q != BSR_START_WRITE;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_q <= BSR_START_NONE;
        end else if (kr) begin
            last_q <= start_rd ? BSR_START_READ :
                      start_wr ? BSR_START_WRITE : BSR_START_NONE;
        end
    end

    // -------------------------------------------------------------------
    // storage: one line of four words per address
    // -------------------------------------------------------------------
    logic [WORD_W-1:0] mem [2**(ADDR_W+2)];

    // -------------------------------------------------------------------
    // write port
    // -------------------------------------------------------------------
    logic [BSR_WR_DEPTH-1:0] wr_line_q;
    logic [ADDR_W-1:0]       waddr_q;
    logic [WORD_W-1:0]       wbuf_q  [BSR_BURST-1];
    logic [NB-1:0]           wmask_q [BSR_BURST-1];
    logic [WORD_W-1:0]       wd_c    [BSR_BURST];
    logic [NB-1:0]           wm_c    [BSR_BURST];
    logic                    commit;
    logic                    wr_pend;

    assign commit  = knr && wr_line_q[BSR_WR_DEPTH-1];
    assign wr_pend = |wr_line_q[BSR_WR_DEPTH-1:1];

    // inputs are looked at only in the phases of a started burst
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_line_q <= '0;
            waddr_q   <= '0;
            for (int i = 0; i < BSR_BURST - 1; i++) begin
                wbuf_q[i]  <= '0;
                wmask_q[i] <= '0;
            end
        end else if (edge_k) begin
            wr_line_q <= {wr_line_q[BSR_WR_DEPTH-2:0], start_wr};
            if (wr_line_q[0]) begin
                waddr_q <= addr_s;
                for (int i = 0; i < BSR_BURST - 1; i++) begin
                    wmask_q[i] <= '0;
                end
            end
            for (int i = 0; i < BSR_BURST - 1; i++) begin
                if (wr_line_q[1+i]) begin
                    wbuf_q[i]  <= d_s;
                    wmask_q[i] <= ~bws_n_s;
                end
            end
        end
    end

    // last word joins the first three straight from the pins on the commit edge
    always_comb begin
        for (int i = 0; i < BSR_BURST - 1; i++) begin
            wd_c[i] = wbuf_q[i];
            wm_c[i] = wmask_q[i];
        end
        wd_c[BSR_BURST-1] = d_s;
        wm_c[BSR_BURST-1] = commit ? ~bws_n_s : '0;
    end

    always_ff @(posedge clk) begin
        if (commit) begin
            for (int i = 0; i < BSR_BURST; i++) begin
                for (int b = 0; b < NB; b++) begin
                    if (wm_c[i][b]) begin
                        mem[{waddr_q, 2'(i)}][b*BSR_BYTE_W +: BSR_BYTE_W] <=
                            wd_c[i][b*BSR_BYTE_W +: BSR_BYTE_W];
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------
    logic [BSR_RD_DEPTH-1:0] rd_vld_q;
    logic [ADDR_W-1:0]       rd_addr_q [BSR_RD_DEPTH];
    int                      rd_first;
    logic                    rd_hit;
    logic                    rd_flag;
    logic [1:0]              rd_idx;
    logic [ADDR_W-1:0]       rd_addr;
    logic [WORD_W-1:0]       rd_word;

    assign rd_first = pll_on_s ? BSR_RD_FIRST_PLL : BSR_RD_FIRST_LEG;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_vld_q <= '0;
            for (int j = 0; j < BSR_RD_DEPTH; j++) begin
                rd_addr_q[j] <= '0;
            end
        end else if (edge_k) begin
            rd_vld_q     <= {rd_vld_q[BSR_RD_DEPTH-2:0], start_rd};
            rd_addr_q[0] <= addr_s;
            for (int j = 1; j < BSR_RD_DEPTH; j++) begin
                rd_addr_q[j] <= rd_addr_q[j-1];
            end
        end
    end

    // reads start two rises apart, so at most one burst owns the output at a time
    always_comb begin
        rd_hit  = 1'b0;
        rd_flag = 1'b0;
        rd_idx  = '0;
        rd_addr = rd_addr_q[0];
        for (int i = 0; i < BSR_BURST; i++) begin
            if (rd_vld_q[rd_first+i-1]) begin
                rd_hit  = 1'b1;
                rd_idx  = 2'(i);
                rd_addr = rd_addr_q[rd_first+i-1];
            end
            if (rd_vld_q[rd_first+i-2]) begin
                rd_flag = 1'b1;
            end
        end
        rd_word = mem[{rd_addr, rd_idx}];
        for (int b = 0; b < NB; b++) begin
            if (wr_pend && waddr_q == rd_addr && wm_c[rd_idx][b]) begin
                rd_word[b*BSR_BYTE_W +: BSR_BYTE_W] =
                    wd_c[rd_idx][b*BSR_BYTE_W +: BSR_BYTE_W];
            end
        end
    end

    // -------------------------------------------------------------------
    // output registers and echo clocks
    // -------------------------------------------------------------------
    logic [WORD_W-1:0] q_q;
    logic              q_oe_n_q;
    logic              vld_q;
    logic              echo_q;
    logic              echo_n_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_q      <= '0;
            q_oe_n_q <= 1'b1;
            vld_q    <= 1'b0;
        end else if (edge_k) begin
            vld_q <= rd_flag;
            if (rd_hit) begin
                q_q      <= rd_word;
                q_oe_n_q <= 1'b0;
            end else if (knr) begin
                q_oe_n_q <= 1'b1;
            end
        end
    end

    // echo edges land in the same clk cycle as the data they frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            echo_q   <= 1'b0;
            echo_n_q <= 1'b0;
        end else begin
            echo_q   <= k_s;
            echo_n_q <= kn_s;
        end
    end

    // -------------------------------------------------------------------
    // pll lock model and impedance update tick
    // -------------------------------------------------------------------
    logic [15:0]   gap_q;
    logic [15:0]   period_q;
    logic [LW-1:0] lock_cnt_q;
    logic [ZW-1:0] zq_cnt_q;
    logic          stall;

    // a half period stretched by the stop time counts as the clock stopping
    // one bit wider so the all-ones start value cannot wrap into a false stall
    assign stall = {1'b0, gap_q} > {1'b0, period_q} + 17'(BSR_PLL_STOP_CYC);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gap_q      <= '0;
            period_q   <= '1;
            lock_cnt_q <= '0;
            pll_locked <= 1'b0;
        end else begin
            if (edge_k) begin
                gap_q    <= '0;
                period_q <= gap_q;
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 1'b1;
            end
            if (!pll_on_s || stall) begin
                lock_cnt_q <= '0;
            end else if (lock_cnt_q != LW'(PLL_LOCK_CYC)) begin
                lock_cnt_q <= lock_cnt_q + 1'b1;
            end
            pll_locked <= pll_on_s && lock_cnt_q == LW'(PLL_LOCK_CYC);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            zq_cnt_q         <= '0;
            impedance_update <= 1'b0;
        end else begin
            impedance_update <= kr && zq_cnt_q == ZW'(BSR_ZQ_PERIOD - 1);
            if (kr) begin
                zq_cnt_q <= zq_cnt_q + 1'b1;
            end
        end
    end

    // read data and write data never share pins
    assign link.q               = q_q;
    assign link.q_oe_n          = q_oe_n_q;
    assign link.read_data_valid = vld_q;
    assign link.echo_clock      = echo_q;
    assign link.echo_clock_n    = echo_n_q;

endmodule : bsr_sram_dev

// [testbench/bsr_link_chk.sv]
module bsr_link_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic pll_disable_n,
    input wire logic q_oe_n,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic read_data_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // link properties, all in clk cycles
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    k_pair_a: assert property (k_n == !k)
        else $error("k_n is not the complement of k");
    echo_true_a: assert property ($rose(k) |-> ##[1:4] $rose(echo_clock))
        else $error("echo clock did not follow k");
    echo_comp_a: assert property ($rose(k_n) |-> ##[1:4] $rose(echo_clock_n))
        else $error("echo clock did not follow k_n");
    rd_sel_short_a: assert property (
        $fell(read_port_select_n) |-> ##[1:15] read_port_select_n)
        else $error("read select held over two k rises");
    wr_sel_short_a: assert property (
        $fell(write_port_select_n) |-> ##[1:15] write_port_select_n)
        else $error("write select held over two k rises");
    valid_lead_a: assert property (
        $fell(q_oe_n) |-> read_data_valid && $past(read_data_valid, 8))
        else $error("read data without leading valid flag");
    valid_word_a: assert property (
        $rose(read_data_valid) && q_oe_n |-> ##[8:12] $fell(q_oe_n))
        else $error("valid flag not followed by data");
    pll_lat_a: assert property ($rose(k) && !read_port_select_n && pll_disable_n
        && !read_data_valid && q_oe_n |-> ##[44:60] $fell(q_oe_n))
        else $error("read latency wrong with pll on");
    leg_lat_a: assert property ($rose(k) && !read_port_select_n && !pll_disable_n
        && !read_data_valid && q_oe_n |-> ##[14:30] $fell(q_oe_n))
        else $error("read latency wrong with pll off");
    reset_idle_a: assert property ($rose(reset_n) |-> q_oe_n && !read_data_valid)
        else $error("read port active after reset");
endmodule : bsr_link_chk

// [testbench/dual_port_burst4_ddr_sram_if_bench.sv]
module dual_port_burst4_ddr_sram_if_bench;
    import bsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset_n, upd_n, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic        pll_locked, imp_upd;
    logic [3:0]  cmd_addr;
    logic [71:0] cmd_wdata, rsp_rdata;
    logic [7:0]  cmd_wbyte_n;
    logic [71:0] mem [16];
    int          n_errors, n_checks, cnt;

    bsr_link_if #(.WORD_W(18), .ADDR_W(4)) link ();
    bsr_sram_dev #(.ADDR_W(4), .PLL_LOCK_CYC(50)) i_bsr_sram_dev (
        .clk(clk), .reset_n(reset_n), .link(link), .pll_locked(pll_locked),
        .impedance_update(imp_upd));
    bsr_sram_ctl #(.ADDR_W(4)) i_bsr_sram_ctl (
        .clk(clk), .reset_n(reset_n), .link(link), .user_pll_disable_n(upd_n),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wbyte_n(cmd_wbyte_n), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    bsr_link_chk i_chk (
        .clk(clk), .reset_n(reset_n), .k(link.k), .k_n(link.k_n),
        .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n),
        .pll_disable_n(link.pll_disable_n), .q_oe_n(link.q_oe_n),
        .echo_clock(link.echo_clock), .echo_clock_n(link.echo_clock_n),
        .read_data_valid(link.read_data_valid));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----
    // tasks
    // ----
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one command; a read compares against the byte-masked shadow copy
    task automatic cmd(input logic wr, input logic [3:0] a, input logic [71:0] wd,
                       input logic [7:0] bn);
        @(posedge clk);
        cmd_valid   <= 1'b1;
        cmd_write   <= wr;
        cmd_addr    <= a;
        cmd_wdata   <= wd;
        cmd_wbyte_n <= bn;
        repeat (400) begin
            @(negedge clk);
            if (cmd_ready === 1'b1) break;
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        if (wr) begin
            for (int b = 0; b < 8; b++) begin
                if (!bn[b]) mem[a][b*9 +: 9] = wd[b*9 +: 9];
            end
        end else begin
            repeat (400) begin
                @(negedge clk);
                if (rsp_valid === 1'b1) break;
            end
            chk(rsp_rdata, mem[a]);
        end
    endtask : cmd

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        #640000;
        n_errors++;
        close_out();
    end

    initial begin
        reset_n = 1'b0; upd_n = 1'b1; cmd_valid = 1'b0; cmd_write = 1'b0;
        cmd_addr = 4'h0; cmd_wdata = 72'h0; cmd_wbyte_n = 8'hFF;
        n_errors = 0; n_checks = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (400) begin
            @(negedge clk);
            if (pll_locked === 1'b1) break;
        end
        chk({71'h0, pll_locked}, 72'h1);
        cmd(1'b1, 4'h3, 72'hABCDEF0123456789AB, 8'h00);
        cmd(1'b0, 4'h3, 72'h0, 8'hFF);
        cmd(1'b1, 4'h3, 72'h13579BDF02468ACE11, 8'hA5);
        cmd(1'b0, 4'h3, 72'h0, 8'hFF);
        cmd(1'b1, 4'hF, 72'h0F0F0F0F0F0F0F0F0F, 8'h00);
        cmd(1'b0, 4'hF, 72'h0, 8'hFF);
        // latency mode only changes while the link is idle
        @(posedge clk);
        upd_n <= 1'b0;
        repeat (40) @(posedge clk);
        cmd(1'b1, 4'hF, 72'hFFEEDDCCBBAA998877, 8'h3C);
        cmd(1'b0, 4'hF, 72'h0, 8'hFF);
        cmd(1'b0, 4'h3, 72'h0, 8'hFF);
        repeat (25000) begin
            @(negedge clk);
            if (imp_upd === 1'b1) break;
        end
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (imp_upd !== 1'b1 && cnt < 25000);
        chk(72'(cnt), 72'(BSR_ZQ_PERIOD * 2 * BSR_K_HALF_CYC));
        close_out();
    end
endmodule : dual_port_burst4_ddr_sram_if_bench
